// ===== src/ts_timer_regs.svh
// Offsets, field positions, reset values and timing figures of the timestamp timer.
// Assumes the includer wants plain `define macros; no code lives here.
`ifndef TS_TIMER_REGS_SVH
`define TS_TIMER_REGS_SVH
`define TS_OFS_CTRL     8'h00
`define TS_OFS_DMASK    8'h04
`define TS_OFS_PRE_LO   8'h08
`define TS_OFS_PRE_HI   8'h0c
`define TS_OFS_CNT_LO   8'h10
`define TS_OFS_CNT_HI   8'h14
`define TS_OFS_STAT     8'h18
`define TS_OFS_MASK     8'h1c
`define TS_CTRL_TSEN    0
`define TS_CTRL_HALT    1
`define TS_CTRL_SRC     2
`define TS_CTRL_GATE    4
`define TS_CTRL_LOAD    8
`define TS_CTRL_CAP     12
`define TS_CTRL_POL     16
`define TS_CTRL_OSEL    20
`define TS_ST_ZERO      0
`define TS_ST_LOAD      1
`define TS_ST_CAP       2
`define TS_ST_W         3
`define TS_CTRL_RST     32'h0000_0000
`define TS_DMASK_RST    32'h0000_0001
`define TS_PRESET_RST   48'h0000_0000_0000
`define TS_SYS_MHZ      125
`define TS_TICK_MHZ     20
`endif

// ===== src/ts_timer_pkg.sv
// Types shared by the timestamp timer: mode encodings and the stream word.
// Assumes the field positions of ts_timer_regs.svh.
package ts_timer_pkg;
  typedef enum logic [1:0] {SRC_INT = 2'h0, SRC_AUX_PORT_ONE = 2'h1, SRC_AUX_PORT_TWO = 2'h2, SRC_REJ = 2'h3} cnt_src_t;
  typedef enum logic [1:0] {GATE_ON = 2'h0, GATE_AUX_PORT_TWO = 2'h1, GATE_AUX_PORT_ONE = 2'h2, GATE_REJ = 2'h3} gate_t;
  typedef enum logic [2:0] {LD_SW = 3'h0, LD_AUX_PORT_TWO = 3'h1, LD_AUX_PORT_ONE = 3'h2, LD_REJ = 3'h3,
                            LD_WRAP = 3'h4} load_mode_t;
  typedef enum logic [2:0] {CAP_DOR = 3'h0, CAP_DOR_AUX_PORT_TWO = 3'h1, CAP_DOR_AUX_PORT_ONE = 3'h2, CAP_DOR_REJ = 3'h3,
                            CAP_CSTART = 3'h4, CAP_CEND = 3'h5, CAP_COK = 3'h6, CAP_SW = 3'h7} cap_src_t;
  typedef struct packed {
    logic        valid;
    logic [47:0] stamp;
  } ts_word_t;
endpackage

// ===== src/ts_timer.sv
// Down-counting timestamp timer with Wishbone classic register slave and capture into the list stream.
// Assumes one clock, synchronous reset, and asynchronous pins for aux, reject and dead-time inputs.
// Function
// - With timestamping on, each capture event puts the 48-bit timer value into the stream.
// - Timer loads a programmable preset and counts down toward zero.
// - With halt enabled, reaching zero stops the acquisition.
// - Count source is internal 20 MHz or edges of aux one, aux two or reject.
// - Timer advances only while acquisition is on, optionally also gated by an input.
// - Preset load trigger is software start or an aux one, aux two or reject event.
// - Wrap mode reloads the preset in place of reaching zero and, with halt off, keeps counting.
// - Capture trigger is dead-time OR, OR with an input, coincidence start or end.
// - Dead-time OR only combines converters whose enable bit is set.
// - Aux inputs for load or capture use the polarity set for that connector.
// - Each aux input polarity is programmable active high or active low.
// - Preset-reached output on aux two asserts at zero only with halt enabled.
// - Timer-load output on aux two signals each preset reload.
//
// Design decisions made here: the Wishbone register port and the register addresses.
`include "ts_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ts_timer
  import ts_timer_pkg::*;
#(
  parameter int NADC = 4,
  parameter int TW   = 48
) (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            wb_cyc,
  input  wire logic            wb_stb,
  input  wire logic            wb_we,
  input  wire logic [7:0]      wb_adr,
  input  wire logic [3:0]      wb_sel,
  input  wire logic [31:0]     wb_dat_w,
  output logic      [31:0]     wb_dat_r,
  output logic                 wb_ack,
  input  wire logic            acq_on,
  input  wire logic            acq_start,
  input  wire logic            coinc_start,
  input  wire logic            coinc_end,
  input  wire logic            aux_port_one,
  input  wire logic            aux_port_two,
  input  wire logic            reject_input,
  input  wire logic [NADC-1:0] dead_in,
  output var ts_word_t         ts_word,
  output logic                 acq_halt,
  output logic                 aux_two_out,
  output logic                 irq
);
  localparam int NP = NADC + 3;
  localparam logic [6:0] PH_STEP = 7'(`TS_TICK_MHZ);
  localparam logic [6:0] PH_MOD  = 7'(`TS_SYS_MHZ);

  logic [NP-1:0] s1_q, s2_q, pv_q, act, pact, rise;
  logic [31:0]   ctrl_q, ctrl_d, dmask_q, dmask_d, rdat_d;
  logic [TW-1:0] pre_q, pre_d, cnt_q, cnt_d;
  logic [`TS_ST_W-1:0] st_q, st_d, imask_q, imask_d, st_clr, st_set;
  logic          ack_d, req;
  logic [6:0]    ph_q, ph_d;
  logic [7:0]    ph_sum;
  logic          tick, src_tick, gate_ok, adv, load_evt, reload, zero_evt, cap_evt, ored_dead_signal;
  logic          halt_d, reached_q, reached_d, load_q, out_q, out_d;
  ts_word_t      ts_d;
  logic          ts_en, halt_en;
  cnt_src_t      src;
  gate_t         gsel;
  load_mode_t    lmode;
  cap_src_t      csel;
  logic [2:0]    pol;

  assign ts_en   = ctrl_q[`TS_CTRL_TSEN];
  assign halt_en = ctrl_q[`TS_CTRL_HALT];
  assign src     = cnt_src_t'(ctrl_q[`TS_CTRL_SRC +: 2]);
  assign gsel    = gate_t'(ctrl_q[`TS_CTRL_GATE +: 2]);
  assign lmode   = load_mode_t'(ctrl_q[`TS_CTRL_LOAD +: 3]);
  assign csel    = cap_src_t'(ctrl_q[`TS_CTRL_CAP +: 3]);
  assign pol     = ctrl_q[`TS_CTRL_POL +: 3];

  // Two-flop synchronisers plus a delay flop; the first stage is never looked at.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      pv_q <= '0;
    end else begin
      s1_q <= {dead_in, reject_input, aux_port_two, aux_port_one};
      s2_q <= s1_q;
      pv_q <= s2_q;
    end
  end

  // Both levels of the edge detector pass through the current polarity, so a polarity flip is no edge.
  for (genvar i = 0; i < NP; i++) begin : g_pin
    if (i < 3) begin : g_aux
      assign act[i]  = s2_q[i] ^ pol[i];
      assign pact[i] = pv_q[i] ^ pol[i];
    end else begin : g_dead
      assign act[i]  = s2_q[i];
      assign pact[i] = pv_q[i];
    end
    assign rise[i] = act[i] & ~pact[i];
  end

  // The dead-time OR only looks at converters enabled in the mask.
  assign ored_dead_signal = |(rise[NP-1:3] & dmask_q[NADC-1:0]);

  // Fractional divider: 20 ticks every 125 cycles, evenly spread, no integer ratio needed.
  always_comb begin
    ph_sum = {1'b0, ph_q} + {1'b0, PH_STEP};
    tick   = (ph_sum >= {1'b0, PH_MOD});
    ph_d   = tick ? 7'(ph_sum - {1'b0, PH_MOD}) : ph_sum[6:0];
  end

  // Count source, gate, load and capture selection.
  always_comb begin
    case (src)
      SRC_INT:  src_tick = tick;
      SRC_AUX_PORT_ONE: src_tick = rise[0];
      SRC_AUX_PORT_TWO: src_tick = rise[1];
      SRC_REJ:  src_tick = rise[2];
      default:  src_tick = 1'b0;
    endcase
    case (gsel)
      GATE_ON:   gate_ok = 1'b1;
      GATE_AUX_PORT_TWO: gate_ok = act[1];
      GATE_AUX_PORT_ONE: gate_ok = act[0];
      GATE_REJ:  gate_ok = act[2];
      default:   gate_ok = 1'b0;
    endcase
    case (lmode)
      LD_SW:   load_evt = acq_start;
      LD_AUX_PORT_TWO: load_evt = rise[1];
      LD_AUX_PORT_ONE: load_evt = rise[0];
      LD_REJ:  load_evt = rise[2];
      default: load_evt = 1'b0;
    endcase
    case (csel)
      CAP_DOR:      cap_evt = ored_dead_signal;
      CAP_DOR_AUX_PORT_TWO: cap_evt = ored_dead_signal | rise[1];
      CAP_DOR_AUX_PORT_ONE: cap_evt = ored_dead_signal | rise[0];
      CAP_DOR_REJ:  cap_evt = ored_dead_signal | rise[2];
      CAP_CSTART:   cap_evt = coinc_start;
      CAP_CEND:     cap_evt = coinc_end;
      CAP_COK:      cap_evt = coinc_end;
      default:      cap_evt = 1'b0;
    endcase
  end

  assign adv = acq_on & gate_ok & src_tick;

  // Timer next state; an explicit load wins over counting in the same cycle.
  always_comb begin
    cnt_d    = cnt_q;
    reload   = 1'b0;
    zero_evt = 1'b0;
    if (load_evt) begin
      cnt_d  = pre_q;
      reload = 1'b1;
    end else if (adv) begin
      if (cnt_q == '0) begin
        if (lmode == LD_WRAP) begin
          cnt_d  = pre_q;
          reload = 1'b1;
        end
      end else if (cnt_q == TW'(1)) begin
        zero_evt = 1'b1;
        if (lmode == LD_WRAP) begin
          cnt_d  = pre_q;
          reload = 1'b1;
        end else begin
          cnt_d = '0;
        end
      end else begin
        cnt_d = cnt_q - TW'(1);
      end
    end
    halt_d    = zero_evt & halt_en;
    reached_d = reload ? 1'b0 : (reached_q | (zero_evt & halt_en));
    out_d     = ctrl_q[`TS_CTRL_OSEL] ? reload : reached_d;
    ts_d.valid = ts_en & cap_evt;
    ts_d.stamp = cnt_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ph_q        <= '0;
      cnt_q       <= `TS_PRESET_RST;
      acq_halt    <= 1'b0;
      reached_q   <= 1'b0;
      load_q      <= 1'b0;
      out_q       <= 1'b0;
      ts_word     <= '0;
    end else begin
      ph_q        <= ph_d;
      cnt_q       <= cnt_d;
      acq_halt    <= halt_d;
      reached_q   <= reached_d;
      load_q      <= reload;
      out_q       <= out_d;
      ts_word     <= ts_d;
    end
  end
  assign aux_two_out = out_q;

  // Byte-lane merge for writes under wb_sel.
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register slave: one wait state, ack for one cycle, unmapped reads return zero.
  always_comb begin
    req     = wb_cyc & wb_stb & ~wb_ack;
    ack_d   = req;
    ctrl_d  = ctrl_q;
    dmask_d = dmask_q;
    pre_d   = pre_q;
    imask_d = imask_q;
    st_clr  = '0;
    rdat_d  = '0;
    if (req && wb_we) begin
      case (wb_adr)
        `TS_OFS_CTRL:   ctrl_d  = wmerge(ctrl_q, wb_dat_w, wb_sel);
        `TS_OFS_DMASK:  dmask_d = wmerge(dmask_q, wb_dat_w, wb_sel);
        `TS_OFS_PRE_LO: pre_d[31:0] = wmerge(pre_q[31:0], wb_dat_w, wb_sel);
        `TS_OFS_PRE_HI: pre_d[TW-1:32] = (TW-32)'(wmerge(32'(pre_q[TW-1:32]), wb_dat_w, wb_sel));
        `TS_OFS_STAT:   st_clr  = wb_sel[0] ? wb_dat_w[`TS_ST_W-1:0] : '0;
        `TS_OFS_MASK:   imask_d = wb_sel[0] ? wb_dat_w[`TS_ST_W-1:0] : imask_q;
        default: ;
      endcase
    end
    if (req && !wb_we) begin
      case (wb_adr)
        `TS_OFS_CTRL:   rdat_d = ctrl_q;
        `TS_OFS_DMASK:  rdat_d = dmask_q;
        `TS_OFS_PRE_LO: rdat_d = pre_q[31:0];
        `TS_OFS_PRE_HI: rdat_d = 32'(pre_q[TW-1:32]);
        `TS_OFS_CNT_LO: rdat_d = cnt_q[31:0];
        `TS_OFS_CNT_HI: rdat_d = 32'(cnt_q[TW-1:32]);
        `TS_OFS_STAT:   rdat_d = 32'(st_q);
        `TS_OFS_MASK:   rdat_d = 32'(imask_q);
        default:        rdat_d = '0;
      endcase
    end
    // A new event beats a simultaneous write-one-to-clear.
    st_set = {ts_d.valid, reload, zero_evt};
    st_d   = (st_q & ~st_clr) | st_set;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= '0;
      ctrl_q   <= `TS_CTRL_RST;
      dmask_q  <= `TS_DMASK_RST;
      pre_q    <= `TS_PRESET_RST;
      st_q     <= '0;
      imask_q  <= '0;
    end else begin
      wb_ack   <= ack_d;
      wb_dat_r <= rdat_d;
      ctrl_q   <= ctrl_d;
      dmask_q  <= dmask_d;
      pre_q    <= pre_d;
      st_q     <= st_d;
      imask_q  <= imask_d;
    end
  end
  assign irq = |(st_q & imask_q);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ack_pulse: assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack) else $error("no ack after request");
  a_load_value: assert property (load_evt |=> cnt_q == $past(pre_q) && load_q)
    else $error("load did not take preset");
  a_count_down: assert property (adv && !load_evt && cnt_q > TW'(1) |=> cnt_q == $past(cnt_q) - TW'(1))
    else $error("count did not decrement");
  a_halt_zero: assert property (cnt_q == TW'(1) && adv && !load_evt && halt_en |=> acq_halt)
    else $error("no halt at zero");
  a_no_halt: assert property (!halt_en |=> !acq_halt)
    else $error("halt without option");
  a_hold_off: assert property (!acq_on && !load_evt |=> cnt_q == $past(cnt_q))
    else $error("counted while acquisition off");
  a_tick_space: assert property (tick |=> !tick [*5])
    else $error("internal tick too fast");
  a_wrap_reload: assert property (lmode == LD_WRAP && adv && !load_evt && cnt_q == TW'(1) |=> cnt_q == $past(pre_q))
    else $error("wrap did not reload");
  a_stamp_word: assert property (ts_en && cap_evt |=> ts_word.valid && ts_word.stamp == $past(cnt_q))
    else $error("stamp missing or wrong");
  a_dor_masked: assert property (ts_en && csel == CAP_DOR && !dmask_q[1] && rise[4] && !rise[3] |=> !ts_word.valid)
    else $error("masked dead edge captured");
  a_sync_lat: assert property ($rose(s2_q[0]) && !pol[0] && $stable(pol) |-> rise[0])
    else $error("edge not detected after sync");
  a_reach_out: assert property (!halt_en && !reached_q |=> !reached_q)
    else $error("reached without halt option");

  c_capture: cover property (ts_en && cap_evt ##1 ts_word.valid);
  c_wrap: cover property (lmode == LD_WRAP && zero_evt ##1 load_q);
  c_halt: cover property (acq_halt);
  c_irq: cover property (irq ##1 wb_ack);
endmodule // ts_timer
`default_nettype wire

// ===== sim/acq_ctl_model.sv
// Acquisition control and list stream sink that sit beside the timestamp timer.
// Assumes one clock with synchronous active-high reset; the bench asks for runs and stops.
`timescale 1ns/1ps
`default_nettype none
module acq_ctl_model
  import ts_timer_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     rst,
  input  wire logic     run_req,
  input  wire logic     stop_req,
  input  wire logic     acq_halt,
  input  wire ts_word_t ts_word,
  output logic          acq_on,
  output logic          acq_start,
  output logic [15:0]   words
);
  // Halt arrives as a pulse only, so the running state is latched here.
  always_ff @(posedge clk_sys) begin
    acq_start <= run_req & ~rst;
    if (rst) begin
      acq_on <= 1'b0;
      words  <= 16'h0000;
    end else begin
      if (acq_halt) begin
        acq_on <= 1'b0;
      end else if (run_req) begin
        acq_on <= 1'b1;
      end else if (stop_req) begin
        acq_on <= 1'b0;
      end
      words <= words + 16'(ts_word.valid);
    end
  end
endmodule // acq_ctl_model
`default_nettype wire

// ===== sim/timestamp_timer_capture_bench.sv
// Self-checking bench of the timestamp timer: register bus, pins, stream and halt.
// Assumes the acquisition model beside the design; expected stamps queue up for the watcher.
`include "ts_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module timestamp_timer_capture_bench import ts_timer_pkg::*; ();
  logic        clk_sys, rst, wb_cyc, wb_stb, wb_we, wb_ack, acq_on, acq_start, acq_halt;
  logic        aux_two_out, irq, run_req, stop_req;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic [8:0]  pv;
  logic [15:0] words;
  logic [47:0] pre, e;
  logic [47:0] exp_q[$];
  ts_word_t    ts_word;
  int          error_cnt = 0, comparisons = 0, halts = 0, out_hi = 0, n, k, t_ns;
  // Pin levels in one vector: dead 3:0, aux two 4, aux one 5, reject 6, coinc start 7, coinc end 8.
  ts_timer u_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .acq_on(acq_on), .acq_start(acq_start), .coinc_start(pv[7]), .coinc_end(pv[8]),
    .aux_port_one(pv[5]), .aux_port_two(pv[4]), .reject_input(pv[6]), .dead_in(pv[3:0]),
    .ts_word(ts_word), .acq_halt(acq_halt), .aux_two_out(aux_two_out), .irq(irq));
  acq_ctl_model u_acq (.clk_sys(clk_sys), .rst(rst), .run_req(run_req), .stop_req(stop_req),
    .acq_halt(acq_halt), .ts_word(ts_word), .acq_on(acq_on), .acq_start(acq_start), .words(words));
  // Verdict and end of run.
  task automatic results();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_dat_w <= d;
    wb_sel   <= 4'hf;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wb_ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      error_cnt++;
      results();
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // Pins keep the toggled level; coincidence strobes last one cycle.
  task automatic fire(input logic [8:0] m);
    @(posedge clk_sys);
    pv <= pv ^ m;
    @(posedge clk_sys);
    pv <= pv ^ (m & 9'h180);
    repeat (9) @(posedge clk_sys);
  endtask
  task automatic req(input logic s);
    @(posedge clk_sys);
    run_req  <= s;
    stop_req <= ~s;
    @(posedge clk_sys);
    run_req  <= 1'b0;
    stop_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Watcher: each stream word takes the oldest expected stamp.
  always @(posedge clk_sys) begin
    if (ts_word.valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : ~ts_word.stamp;
      `CHK("stamp", e, ts_word.stamp)
    end
    halts  <= halts + int'(acq_halt === 1'b1);
    out_hi <= out_hi + int'(aux_two_out === 1'b1);
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
  // Main sequence.
  initial begin
    {rst, wb_cyc, wb_stb, wb_we, run_req, stop_req} = 6'b100000;
    {wb_adr, wb_sel, wb_dat_w, pv} = '0;
    void'($urandom(94346));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, with the unmapped word written first and read back as zero.
    wb(8'h20, 1'b1, 32'hffff_ffff);
    for (int i = 0; i < 9; i++) begin
      wb(8'(i * 4), 1'b0, 32'h0);
      `CHK("reset_rd", (i == 1) ? 32'h1 : 32'h0, rd)
    end
    // Load a random 48-bit preset by software start; the gate on idle aux one keeps it from counting during the short run.
    pre = {16'($urandom), 32'($urandom)};
    wb(`TS_OFS_PRE_LO, 1'b1, pre[31:0]);
    wb(`TS_OFS_PRE_HI, 1'b1, {16'h0, pre[47:32]});
    wb(`TS_OFS_CTRL, 1'b1, 32'h0000_0020);
    wb(`TS_OFS_MASK, 1'b1, 32'h4);
    req(1'b1);
    req(1'b0);
    wb(`TS_OFS_CNT_LO, 1'b0, 32'h0);
    `CHK("cnt_lo", pre[31:0], rd)
    wb(`TS_OFS_CNT_HI, 1'b0, 32'h0);
    `CHK("cnt_hi", {16'h0, pre[47:32]}, rd)
    // Every capture mode; converter 1 is masked off and must never capture.
    for (int c = 0; c < 8; c++) begin
      wb(`TS_OFS_CTRL, 1'b1, 32'h0000_0521 | (c << 12));
      if (c < 7) exp_q.push_back(pre);
      n = (c == 0) ? 9'h001 : (c == 1) ? 9'h011 : (c == 2) ? 9'h020 : (c == 3) ? 9'h040 : (c == 4) ? 9'h080 : 9'h100;
      if (c == 0) fire(9'h002);
      fire(9'(n) | 9'h002);
      fire((9'(n) & 9'h07f) | ((c == 0) ? 9'h000 : 9'h002));
    end
    `CHK("words", 16'd7, words)
    `CHK("irq_set", 1'b1, irq)
    wb(`TS_OFS_STAT, 1'b0, 32'h0);
    `CHK("status", 32'h6, rd)
    wb(`TS_OFS_STAT, 1'b1, 32'h6);
    `CHK("irq_clr", 1'b0, irq)
    // Active-low aux one: rising is the inactive edge, falling captures.
    wb(`TS_OFS_CTRL, 1'b1, 32'h0001_2521);
    fire(9'h020);
    exp_q.push_back(pre);
    fire(9'h020);
    // Load by aux one with the load pulse routed out.
    pre = 48'h40 + 48'($urandom % 256);
    wb(`TS_OFS_PRE_LO, 1'b1, pre[31:0]);
    wb(`TS_OFS_PRE_HI, 1'b1, 32'h0);
    wb(`TS_OFS_CTRL, 1'b1, 32'h0010_0200);
    n = out_hi;
    fire(9'h020);
    fire(9'h020);
    `CHK("load_out", 1, out_hi - n)
    wb(`TS_OFS_CNT_LO, 1'b0, 32'h0);
    `CHK("cnt_load", pre[31:0], rd)
    // Count aux one edges only while reject opens the gate.
    wb(`TS_OFS_CTRL, 1'b1, 32'h0000_0534);
    req(1'b1);
    repeat (4) fire(9'h020);
    fire(9'h040);
    repeat (6) fire(9'h020);
    fire(9'h040);
    req(1'b0);
    wb(`TS_OFS_CNT_LO, 1'b0, 32'h0);
    `CHK("cnt_ext", pre[31:0] - 32'd3, rd)
    // Count aux two edges while aux two gates; an active-low reject edge reloads the preset.
    wb(`TS_OFS_CTRL, 1'b1, 32'h0004_0318);
    req(1'b1);
    fire(9'h050);
    fire(9'h050);
    fire(9'h010);
    req(1'b0);
    wb(`TS_OFS_CNT_LO, 1'b0, 32'h0);
    `CHK("cnt_rej", pre[31:0] - 32'd1, rd)
    // Halt at zero; a 20 MHz count is 50 ns, so the preset is the time over 50.
    t_ns = 50 * (5 + $urandom % 8);
    pre = 48'(t_ns / 50);
    wb(`TS_OFS_PRE_LO, 1'b1, pre[31:0]);
    wb(`TS_OFS_CTRL, 1'b1, 32'h0000_0002);
    wb(`TS_OFS_MASK, 1'b1, 32'h1);
    n = halts;
    req(1'b1);
    for (k = 6; k < 200 && halts == n; k++) @(posedge clk_sys);
    `CHK("halt_time", 1'b1, k >= (int'(pre) - 1) * 6 && k < 200)
    repeat (2) @(posedge clk_sys);
    `CHK("acq_off", 1'b0, acq_on)
    `CHK("reached", 1'b1, aux_two_out)
    `CHK("irq_zero", 1'b1, irq)
    wb(`TS_OFS_CNT_LO, 1'b0, 32'h0);
    `CHK("cnt_zero", 32'h0, rd)
    // Wrap with halt off: no halt, no preset-reached level, count stays within the preset.
    wb(`TS_OFS_PRE_LO, 1'b1, 32'h3);
    wb(`TS_OFS_CTRL, 1'b1, 32'h0000_0400);
    n = halts;
    req(1'b1);
    repeat (30) @(posedge clk_sys);
    k = out_hi;
    repeat (300) @(posedge clk_sys);
    `CHK("no_reach", k, out_hi)
    `CHK("no_halt", n, halts)
    `CHK("still_on", 1'b1, acq_on)
    wb(`TS_OFS_CNT_LO, 1'b0, 32'h0);
    `CHK("wrap_cnt", 1'b1, rd <= 32'h3)
    req(1'b0);
    `CHK("queue", 0, exp_q.size())
    results();
  end
endmodule // timestamp_timer_capture_bench
`default_nettype wire
